// File: src/sfc_consts.svh
// Opcodes, lengths, status bit positions and reset values
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH

// ======================================
// Opcodes
`define SFC_OP_WR_ON     8'h06
`define SFC_OP_WR_OFF    8'h04
`define SFC_OP_VOL_ARM   8'h50
`define SFC_OP_ST_WR     8'h01
`define SFC_OP_ST_RD     8'h05
`define SFC_OP_ST3_RD    8'h95
`define SFC_OP_ST3_WR    8'hc0
`define SFC_OP_PROG      8'h02
`define SFC_OP_QPROG     8'h32
`define SFC_OP_ER_SECT   8'h20
`define SFC_OP_ER_HALF   8'h52
`define SFC_OP_ER_BLOCK  8'hd8
`define SFC_OP_ER_CHIP   8'hc7
`define SFC_OP_ER_CHIP2  8'h60
`define SFC_OP_SLEEP     8'hb9
`define SFC_OP_WAKE_ID   8'hab
`define SFC_OP_MFR_DEV   8'h90
`define SFC_OP_ID_READ   8'h9f
`define SFC_OP_PARAM     8'h5a
`define SFC_OP_RST_ARM   8'h66
`define SFC_OP_RST_GO    8'h99
`define SFC_OP_QUAD_ON   8'h38
`define SFC_OP_QUAD_OFF  8'hff

// ======================================
// Sequence lengths in bytes, opcode included, and array block count
`define SFC_LEN_ONE      9'd1
`define SFC_LEN_STWR     9'd2
`define SFC_LEN_ADDR_LO  9'd2
`define SFC_LEN_ERASE    9'd4
`define SFC_LEN_ID_HDR   9'd4
`define SFC_LEN_PROG     9'd5
`define SFC_LEN_BLOCKS   9'd256

// ======================================
// Status byte bit positions
`define SFC_SR_BUSY      0
`define SFC_SR_WEL       1
`define SFC_SR_BP_LO     2
`define SFC_SR_SEL_BOT   3
`define SFC_SR_SEL_SECT  4
`define SFC_SR_BP_HI     4
`define SFC_SR_SIDE      5
`define SFC_SR_BOOT      6
`define SFC_SR_PERM      7
`define SFC_S3_TB        0
`define SFC_S3_OTP       1
`define SFC_SR_RESET     6'h00
`define SFC_S3_RESET     2'h0

`endif

// File: src/sfc_pkg.sv
// Types shared by the serial flash command block
package sfc_pkg;

  typedef enum logic [2:0] {ex_stat, ex_prog, ex_sect, ex_half, ex_block, ex_chip} sfc_exec_t;

  typedef enum logic {ph_opcode, ph_body} sfc_phase_t;

  typedef struct packed {
    logic        write_enable_latch;
    logic        busy;
    logic [5:0]  st;
    logic [5:0]  nv;
    logic [1:0]  st3;
    logic [1:0]  nv3;
    logic        tb_done;
    logic        sel_lock;
    logic        quad;
    logic        dpd;
    logic        rst_arm;
    logic        vol_arm;
    sfc_phase_t  phase;
    logic [7:0]  op;
    logic [7:0]  sh;
    logic [11:0] bits;
    logic [23:0] addr;
    logic        alt;
    logic [1:0]  idc;
    logic [7:0]  out_sh;
    logic        out_on;
    logic [3:0]  dq;
    logic [3:0]  oe;
    logic        go;
    sfc_exec_t   kind;
    logic [23:0] eaddr;
    logic        dv;
    logic [7:0]  dbyte;
    logic [23:0] paddr;
  } sfc_core_t;

endpackage : sfc_pkg

// File: src/sfc_link_if.sv
// Synchronised serial link events between sampler and core
`timescale 1ns/1ps
`default_nettype none
interface sfc_link_if;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_high;
  logic       cs_rise;
  logic [3:0] din;
  modport src (output sclk_rise, sclk_fall, cs_high, cs_rise, din);
  modport dst (input sclk_rise, sclk_fall, cs_high, cs_rise, din);
endinterface : sfc_link_if
`default_nettype wire

// File: src/sfc_link_sync.sv
// Two-flop sampler and edge finder for the serial pins
`timescale 1ns/1ps
`default_nettype none
module sfc_link_sync (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       spi_clk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic [3:0] spi_dq_in,
  sfc_link_if.src         link
);
  // {clock, select, data}; select idles high
  logic [5:0] meta;
  logic [5:0] sync;
  logic [1:0] last;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta <= 6'h10;
      sync <= 6'h10;
      last <= 2'h1;
    end else begin
      meta <= {spi_clk_in, spi_cs_n_in, spi_dq_in};
      sync <= meta;
      last <= sync[5:4];
    end
  end

  always_comb begin
    link.sclk_rise = sync[5] & ~last[1]; // [RULE24]
    link.sclk_fall = ~sync[5] & last[1];
    link.cs_high   = sync[4];
    link.cs_rise   = sync[4] & ~last[0];
    link.din       = sync[3:0];
  end
endmodule : sfc_link_sync
`default_nettype wire

// File: src/sfc_protect.sv
// Protected-range decode from status bits and address
`timescale 1ns/1ps
`default_nettype none
`include "sfc_consts.svh"
module sfc_protect (
  input  wire logic [7:0]  status_in,
  input  wire logic        tb_in,
  input  wire logic [23:0] addr_in,
  output logic             hit_out,
  output logic             any_out
);
  logic [2:0] size;
  logic [8:0] span;
  logic [8:0] blk;
  logic       range_hit;
  logic       boot_hit;
  logic       sect;

  always_comb begin
    size = status_in[`SFC_SR_BP_HI:`SFC_SR_BP_LO];
    span = 9'd1 << ({1'b0, size} + 4'd1);
    blk  = {1'b0, addr_in[23:16]};
    sect = status_in[`SFC_SR_SEL_SECT];
    range_hit = 1'b0;
    if (size == 3'd7) begin
      range_hit = 1'b1;
    end else if (size != 3'd0) begin
      unique case ({tb_in, status_in[`SFC_SR_SIDE]})
        2'b00: range_hit = blk >= (`SFC_LEN_BLOCKS - span); // [RULE6]
        2'b01: range_hit = blk < span; // [RULE6]
        2'b10: range_hit = blk < (`SFC_LEN_BLOCKS - span); // [RULE7]
        2'b11: range_hit = blk >= span; // [RULE7]
      endcase
    end
    boot_hit = 1'b0;
    if (status_in[`SFC_SR_BOOT]) begin
      if (status_in[`SFC_SR_SEL_BOT]) begin
        boot_hit = sect ? (addr_in[23:12] == 12'h000) : (addr_in[23:16] == 8'h00); // [RULE8]
      end else begin
        boot_hit = sect ? (&addr_in[23:12]) : (&addr_in[23:16]); // [RULE8]
      end
    end
    hit_out = range_hit | boot_hit;
    any_out = (size != 3'd0) | status_in[`SFC_SR_BOOT];
  end
endmodule : sfc_protect
`default_nettype wire

// File: src/sfc_flash_cmd.sv
// Serial flash command front-end and write protection
`timescale 1ns/1ps
`default_nettype none
`include "sfc_consts.svh"

// What this block does
// [RULE1] Write latch clears on power-up, non-volatile writes, reset
// [RULE2] Modifying commands need write latch set
// [RULE3] Writes accepted only on whole bytes
// [RULE4] Permanent lock freezes protect bits except boot lock bit
// [RULE5] Power-down ignores all but wake
// [RULE6] Top/bottom zero: upper or lower blocks
// [RULE7] Top/bottom one: complement ranges protected
// [RULE8] Boot lock guards end block or sector
// [RULE9] Boot selection bits programmable once only
// [RULE10] Everything shifted most significant bit first
// [RULE11] Reads stream data until select rises
// [RULE12] Writes ending mid-byte are rejected
// [RULE13] Partial program byte: nothing, latch kept
// [RULE14] Program needs address plus data byte
// [RULE15] Sector, half and block erases need exactly three address bytes
// [RULE16] Busy cycle ignores further array commands
// [RULE17] Reset only right after reset arm
// [RULE18] All-ones opcode leaves quad mode
// [RULE19] Volatile arm must directly precede status write
// [RULE20] Status and wake ID repeat continuously
// [RULE21] Maker and device bytes alternate by selector
// [RULE22] Parameter read streams from given address
// [RULE23] Write enable sets the write latch
// [RULE24] Input sampled on rising clock, modes 0/3
// [RULE25] Quad enter makes all transfers four-wide
// [RULE26] Status shows busy during internal cycles
// [RULE27] Select high returns decoder to opcode
module sfc_flash_cmd
  import sfc_pkg::*;
#(
  parameter logic [7:0] MFR_ID  = 8'ha5, // Arbitrary value
  parameter logic [7:0] TYPE_ID = 8'h3c, // Arbitrary value
  parameter logic [7:0] DEV_ID  = 8'h4e  // Arbitrary value
) (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        spi_clk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic [3:0]  spi_dq_in,
  output logic      [3:0]  spi_dq_out,
  output logic      [3:0]  spi_dq_oe_out,
  input  wire logic        array_done_in,
  input  wire logic [7:0]  param_data_in,
  output logic      [23:0] param_addr_out,
  output logic             exec_go_out,
  output var sfc_exec_t    exec_kind_out,
  output logic      [23:0] exec_addr_out,
  output logic             data_valid_out,
  output logic      [7:0]  data_out,
  output logic             busy_out,
  output logic             quad_mode_out,
  output logic             power_down_out
);

  // ======================================
  // Link sampling and protection decode
  sfc_link_if link ();

  sfc_link_sync u_sync (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .spi_clk_in  (spi_clk_in),
    .spi_cs_n_in (spi_cs_n_in),
    .spi_dq_in   (spi_dq_in),
    .link        (link)
  );

  sfc_core_t  s;
  sfc_core_t  next_s;
  logic [7:0] sr;
  logic       prot_hit;
  logic       prot_any;

  sfc_protect u_prot (
    .status_in (sr),
    .tb_in     (s.st3[`SFC_S3_TB]),
    .addr_in   (s.addr),
    .hit_out   (prot_hit),
    .any_out   (prot_any)
  );

  // ======================================
  // Status write merge
  function automatic logic [5:0] sr_merge(
    input logic [5:0] cur,
    input logic [7:0] w,
    input logic       lock
  );
    logic [7:0] r;
    r = {cur, 2'b00};
    r[`SFC_SR_BOOT] = w[`SFC_SR_BOOT];
    if (!r[`SFC_SR_PERM]) begin
      r[`SFC_SR_PERM]  = w[`SFC_SR_PERM]; // [RULE4]
      r[`SFC_SR_SIDE]  = w[`SFC_SR_SIDE];
      r[`SFC_SR_BP_LO] = w[`SFC_SR_BP_LO];
      if (!lock) begin
        r[`SFC_SR_SEL_SECT:`SFC_SR_SEL_BOT] = w[`SFC_SR_SEL_SECT:`SFC_SR_SEL_BOT]; // [RULE9]
      end
    end
    return r[7:2];
  endfunction : sr_merge

  // ======================================
  // Command engine
  logic [7:0]  sh_new;
  logic [11:0] bits_new;
  logic [8:0]  nb;
  logic [8:0]  seq_nb;
  logic [7:0]  op_now;
  logic        whole;
  logic        awake;
  logic        can_wr;
  logic        one;
  logic        sel;

  always_comb begin
    sr = {s.st, s.write_enable_latch, s.busy}; // [RULE26]
  end

  always_comb begin
    sh_new   = s.quad ? {s.sh[3:0], link.din} : {s.sh[6:0], link.din[0]}; // [RULE10]
    bits_new = s.bits + (s.quad ? 12'd4 : 12'd1);
    nb       = bits_new[11:3];
    seq_nb   = s.bits[11:3];
    whole    = (s.bits[2:0] == 3'd0); // [RULE3] [RULE12]
    one      = whole && (seq_nb == `SFC_LEN_ONE);
    can_wr   = s.write_enable_latch && !s.busy && whole; // [RULE2] [RULE16]
    op_now   = (s.phase == ph_opcode) ? sh_new : s.op;
    awake    = !s.dpd || (op_now == `SFC_OP_WAKE_ID); // [RULE5]
    sel      = s.alt;
    next_s      = s;
    next_s.go   = 1'b0;
    next_s.dv   = 1'b0;
    next_s.busy = s.busy & ~array_done_in;

    // Rising edge: shift in, decode, load output bytes
    if (link.sclk_rise && !link.cs_high) begin // [RULE24]
      next_s.sh   = sh_new;
      next_s.bits = bits_new;
      if (bits_new[2:0] == 3'd0) begin
        if (s.phase == ph_opcode) begin
          next_s.op    = sh_new;
          next_s.phase = ph_body;
        end
        if (nb >= `SFC_LEN_ADDR_LO && nb <= `SFC_LEN_ERASE) begin
          next_s.addr = {s.addr[15:0], sh_new};
        end
        if (awake) begin
          unique case (op_now)
            `SFC_OP_ST_RD: begin
              next_s.out_sh = sr; // [RULE20] [RULE11]
              next_s.out_on = 1'b1;
            end
            `SFC_OP_ST3_RD: begin
              next_s.out_sh = {6'h00, s.st3};
              next_s.out_on = 1'b1;
            end
            `SFC_OP_WAKE_ID: begin
              if (nb >= `SFC_LEN_ID_HDR) begin
                next_s.out_sh = DEV_ID; // [RULE20]
                next_s.out_on = 1'b1;
              end
            end
            `SFC_OP_MFR_DEV: begin
              if (nb >= `SFC_LEN_ID_HDR) begin
                if (nb == `SFC_LEN_ID_HDR) begin
                  sel = sh_new[0]; // [RULE21]
                end
                next_s.out_sh = sel ? DEV_ID : MFR_ID; // [RULE21]
                next_s.alt    = ~sel;
                next_s.out_on = 1'b1;
              end
            end
            `SFC_OP_ID_READ: begin
              next_s.out_sh = (s.idc == 2'd0) ? MFR_ID :
                              (s.idc == 2'd1) ? TYPE_ID : DEV_ID;
              next_s.idc    = (s.idc == 2'd2) ? 2'd0 : s.idc + 2'd1;
              next_s.out_on = 1'b1;
            end
            `SFC_OP_PARAM: begin
              if (nb == `SFC_LEN_ERASE) begin
                next_s.paddr = {s.addr[15:0], sh_new}; // [RULE22]
              end else if (nb >= `SFC_LEN_PROG) begin
                next_s.out_sh = param_data_in; // [RULE22]
                next_s.paddr  = s.paddr + 24'd1;
                next_s.out_on = 1'b1;
              end
            end
            `SFC_OP_PROG,
            `SFC_OP_QPROG: begin
              if (nb >= `SFC_LEN_PROG && !s.dpd) begin
                next_s.dv    = 1'b1;
                next_s.dbyte = sh_new;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end

    // Falling edge: drive next output bit or nibble
    if (link.sclk_fall && s.out_on && !link.cs_high) begin
      if (s.quad) begin
        next_s.dq     = s.out_sh[7:4]; // [RULE10]
        next_s.out_sh = {s.out_sh[3:0], 4'h0};
        next_s.oe     = 4'hf;
      end else begin
        next_s.dq     = {2'b00, s.out_sh[7], 1'b0}; // [RULE10]
        next_s.out_sh = {s.out_sh[6:0], 1'b0};
        next_s.oe     = 4'h2;
      end
    end

    // Select rising: judge and execute the sequence
    if (link.cs_rise && s.bits != 12'd0) begin
      if (s.dpd) begin
        if (s.op == `SFC_OP_WAKE_ID && whole) begin
          next_s.dpd = 1'b0; // [RULE5]
        end
      end else begin
        next_s.rst_arm = 1'b0; // [RULE17]
        next_s.vol_arm = 1'b0; // [RULE19]
        unique case (s.op)
          `SFC_OP_WR_ON: begin
            if (one) begin
              next_s.write_enable_latch = 1'b1; // [RULE23]
            end
          end
          `SFC_OP_WR_OFF: begin
            if (one) begin
              next_s.write_enable_latch = 1'b0; // [RULE1]
            end
          end
          `SFC_OP_VOL_ARM: begin
            next_s.vol_arm = one; // [RULE19]
          end
          `SFC_OP_RST_ARM: begin
            next_s.rst_arm = one; // [RULE17]
          end
          `SFC_OP_RST_GO: begin
            if (one && s.rst_arm) begin // [RULE17]
              next_s.write_enable_latch  = 1'b0; // [RULE1]
              next_s.busy = 1'b0;
              next_s.st   = s.nv;
              next_s.st3  = s.nv3;
              next_s.quad = 1'b0;
            end
          end
          `SFC_OP_QUAD_ON: begin
            if (one) begin
              next_s.quad = 1'b1; // [RULE25]
            end
          end
          `SFC_OP_QUAD_OFF: begin
            if (one) begin
              next_s.quad = 1'b0; // [RULE18]
            end
          end
          `SFC_OP_SLEEP: begin
            if (one) begin
              next_s.dpd = 1'b1; // [RULE5]
            end
          end
          `SFC_OP_ST_WR: begin
            if (whole && seq_nb == `SFC_LEN_STWR) begin
              if (s.vol_arm) begin
                next_s.st = sr_merge(s.st, s.sh, s.sel_lock); // [RULE19]
              end else if (can_wr) begin
                next_s.st       = sr_merge(s.nv, s.sh, s.sel_lock);
                next_s.nv       = sr_merge(s.nv, s.sh, s.sel_lock); // [RULE4]
                next_s.sel_lock = s.sel_lock | s.sh[`SFC_SR_BOOT]; // [RULE9]
                next_s.write_enable_latch      = 1'b0; // [RULE1]
                next_s.go       = 1'b1;
                next_s.kind     = ex_stat;
                next_s.busy     = 1'b1; // [RULE26]
              end
            end
          end
          `SFC_OP_ST3_WR: begin
            if (can_wr && seq_nb == `SFC_LEN_STWR) begin
              if (!s.tb_done) begin
                next_s.st3[`SFC_S3_TB] = s.sh[`SFC_S3_TB]; // [RULE9]
                next_s.nv3[`SFC_S3_TB] = s.sh[`SFC_S3_TB];
                next_s.tb_done         = 1'b1;
              end
              if (!s.nv[5]) begin
                next_s.st3[`SFC_S3_OTP] = s.st3[`SFC_S3_OTP] | s.sh[`SFC_S3_OTP]; // [RULE4]
                next_s.nv3[`SFC_S3_OTP] = s.nv3[`SFC_S3_OTP] | s.sh[`SFC_S3_OTP];
              end
              next_s.write_enable_latch = 1'b0;
            end
          end
          `SFC_OP_PROG,
          `SFC_OP_QPROG: begin
            if (can_wr && seq_nb >= `SFC_LEN_PROG && !prot_hit) begin // [RULE13] [RULE14]
              next_s.write_enable_latch   = 1'b0; // [RULE1]
              next_s.go    = 1'b1;
              next_s.kind  = ex_prog;
              next_s.eaddr = s.addr;
              next_s.busy  = 1'b1;
            end
          end
          `SFC_OP_ER_SECT,
          `SFC_OP_ER_HALF,
          `SFC_OP_ER_BLOCK: begin
            if (can_wr && seq_nb == `SFC_LEN_ERASE && !prot_hit) begin // [RULE15]
              next_s.write_enable_latch   = 1'b0; // [RULE1]
              next_s.go    = 1'b1;
              next_s.kind  = (s.op == `SFC_OP_ER_SECT) ? ex_sect :
                             (s.op == `SFC_OP_ER_HALF) ? ex_half : ex_block;
              next_s.eaddr = s.addr;
              next_s.busy  = 1'b1;
            end
          end
          `SFC_OP_ER_CHIP,
          `SFC_OP_ER_CHIP2: begin
            if (can_wr && one && !prot_any) begin
              next_s.write_enable_latch   = 1'b0; // [RULE1]
              next_s.go    = 1'b1;
              next_s.kind  = ex_chip;
              next_s.eaddr = 24'h000000;
              next_s.busy  = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Select high: drop partial sequence and release pins
    if (link.cs_high) begin
      next_s.phase  = ph_opcode; // [RULE27]
      next_s.bits   = 12'd0;
      next_s.sh     = 8'h00;
      next_s.out_on = 1'b0; // [RULE11]
      next_s.oe     = 4'h0;
      next_s.idc    = 2'd0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0; // [RULE1]
    end else begin
      s <= next_s;
    end
  end

  // ======================================
  // Outputs
  assign spi_dq_out     = s.dq;
  assign spi_dq_oe_out  = s.oe;
  assign param_addr_out = s.paddr;
  assign exec_go_out    = s.go;
  assign exec_kind_out  = s.kind;
  assign exec_addr_out  = s.eaddr;
  assign data_valid_out = s.dv;
  assign data_out       = s.dbyte;
  assign busy_out       = s.busy;
  assign quad_mode_out  = s.quad;
  assign power_down_out = s.dpd;

  // ======================================
  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_go_needs_wel: assert property ( // [RULE2]
    s.go |-> $past(s.write_enable_latch) && !s.write_enable_latch)
    else $error("execution without write latch");

  a_go_not_busy: assert property ( // [RULE16]
    s.go |-> !$past(s.busy) && s.busy)
    else $error("execution during busy cycle");

  a_go_whole_byte: assert property ( // [RULE3]
    link.cs_rise && s.bits[2:0] != 3'd0 |=> !s.go)
    else $error("partial byte sequence executed");

  a_sleep_quiet: assert property ( // [RULE5]
    s.dpd && link.cs_rise && s.op != `SFC_OP_WAKE_ID |=> s.dpd && !s.go)
    else $error("power-down left by other opcode");

  a_perm_hold: assert property ( // [RULE4]
    s.nv[5] |=> s.nv[5] && $stable(s.nv[3:0]))
    else $error("locked protect bits changed");

  a_cs_clear: assert property ( // [RULE27]
    link.cs_high |=> s.phase == ph_opcode && s.bits == 12'd0 && spi_dq_oe_out == 4'h0)
    else $error("decoder not idle with select high");

  a_erase_exact: assert property ( // [RULE15]
    s.go && s.kind inside {ex_sect, ex_half, ex_block} |-> $past(s.bits) == 12'd32)
    else $error("erase executed with wrong length");

  a_prog_min: assert property ( // [RULE14]
    s.go && s.kind == ex_prog |-> $past(s.bits) >= 12'd40)
    else $error("program executed too short");

  a_wel_set: assert property ( // [RULE23]
    link.cs_rise && !s.dpd && s.op == `SFC_OP_WR_ON && s.bits == 12'd8 |=> s.write_enable_latch)
    else $error("write enable did not set latch");

  a_quad_enter: assert property ( // [RULE25]
    link.cs_rise && !s.dpd && s.op == `SFC_OP_QUAD_ON && s.bits == 12'd8 |=> s.quad)
    else $error("quad mode not entered");

  a_reset_armed: assert property ( // [RULE17]
    link.cs_rise && s.op == `SFC_OP_RST_GO && !s.rst_arm && s.quad |=> s.quad)
    else $error("reset without arm");

endmodule : sfc_flash_cmd
`default_nettype wire

// File: test/sfc_host_model.sv
// Serial host model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic      [3:0] dq_out,
  input  wire logic [3:0] dq_in
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    dq_out   = 4'h0;
  end
  task automatic start();
    cs_n_out = 1'b0;
    #32;
  endtask : start
  task automatic put(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      dq_out[0] = v[7-i];
      #32 sclk_out = 1'b1;
      #32 sclk_out = 1'b0;
    end
  endtask : put
  task automatic putq(input logic [7:0] v);
    for (int i = 0; i < 2; i++) begin
      dq_out = (i == 0) ? v[7:4] : v[3:0];
      #32 sclk_out = 1'b1;
      #32 sclk_out = 1'b0;
    end
  endtask : putq
  task automatic get(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      #32 sclk_out = 1'b1;
      v[7-i] = dq_in[1];
      #32 sclk_out = 1'b0;
    end
  endtask : get
  task automatic stop();
    #32 cs_n_out = 1'b1;
    dq_out = ~dq_out;
    #64;
  endtask : stop
endmodule : sfc_host_model
`default_nettype wire

// File: test/sfc_flash_cmd_bench.sv
// Self-checking bench for the serial flash command block
`timescale 1ns/1ps
`default_nettype none
`include "sfc_consts.svh"
module sfc_flash_cmd_bench;
  import sfc_pkg::*;
  logic        sys_clk, reset_n, cs_n, sclk, done, go, dv, busy, quad, pd;
  logic [3:0]  dq_h, dq_d, oe;
  logic [23:0] eaddr;
  logic [7:0]  dat, s;
  sfc_exec_t   kind;
  int          n_mismatch, comparisons, n_go;
  // ======================================
  // Design and host
  sfc_host_model host (.cs_n_out(cs_n), .sclk_out(sclk), .dq_out(dq_h), .dq_in(dq_d));
  sfc_flash_cmd uut (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .spi_clk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_dq_in(dq_h), .spi_dq_out(dq_d), .spi_dq_oe_out(oe), .array_done_in(done),
    .param_data_in(8'h00), .param_addr_out(), .exec_go_out(go), .exec_kind_out(kind),
    .exec_addr_out(eaddr), .data_valid_out(dv), .data_out(dat), .busy_out(busy),
    .quad_mode_out(quad), .power_down_out(pd)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (go === 1'b1) n_go++;
  // ======================================
  // Tasks
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic tx(input logic [39:0] v, input int nb, input int extra);
    host.start();
    for (int k = 0; k < nb; k++) host.put(v[39-8*k -: 8], 8);
    if (extra > 0) host.put(8'h00, extra);
    host.stop();
  endtask : tx
  task automatic st(output logic [7:0] v);
    host.start();
    host.put(`SFC_OP_ST_RD, 8);
    host.get(v);
    host.stop();
  endtask : st
  task automatic finish_cycle();
    @(posedge sys_clk);
    #1 done = 1'b1;
    @(posedge sys_clk);
    #1 done = 1'b0;
    for (int i = 0; i < 8 && busy !== 1'b0; i++) @(posedge sys_clk);
    check("busy_out", {23'h0, busy}, 24'h0);
  endtask : finish_cycle
  // ======================================
  // Sequence
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    reset_n = 1'b0;
    done = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    n_go = 0;
    repeat (4) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    st(s);
    check("status reset", s, 8'h00);
    tx({`SFC_OP_WR_ON, 32'h0}, 1, 0);
    host.start();
    host.put(`SFC_OP_ST_RD, 8);
    host.get(s);
    check("status wel", s, 8'h02);
    host.get(s);
    check("status repeat", s, 8'h02);
    host.stop();
    tx({`SFC_OP_WR_OFF, 32'h0}, 1, 0);
    st(s);
    check("status write_disable_cmd", s, 8'h00);
    tx({`SFC_OP_PROG, 24'h000100, 8'h5a}, 5, 0);
    check("go no wel", n_go, 0);
    tx({`SFC_OP_WR_ON, 32'h0}, 1, 0);
    tx({`SFC_OP_PROG, 24'h000100, 8'h5a}, 5, 3);
    check("go partial", n_go, 0);
    st(s);
    check("wel kept", s, 8'h02);
    tx({`SFC_OP_PROG, 24'h000100, 8'h5a}, 4, 0);
    check("go short", n_go, 0);
    tx({`SFC_OP_PROG, 24'h000100, 8'h5a}, 5, 0);
    check("go prog", n_go, 1);
    check("kind prog", kind, ex_prog);
    check("addr prog", eaddr, 24'h000100);
    check("data prog", dat, 8'h5a);
    st(s);
    check("busy bit", s[0], 1'b1);
    tx({`SFC_OP_WR_ON, 32'h0}, 1, 0);
    tx({`SFC_OP_ER_SECT, 24'h010000, 8'h00}, 4, 0);
    check("go busy", n_go, 1);
    finish_cycle();
    st(s);
    check("status done", s, 8'h02);
    tx({`SFC_OP_WR_ON, 32'h0}, 1, 0);
    tx({`SFC_OP_ER_SECT, 24'h010000, 8'h00}, 5, 0);
    check("go long erase", n_go, 1);
    tx({`SFC_OP_ER_SECT, 24'h010000, 8'h00}, 4, 0);
    check("go erase", n_go, 2);
    check("kind erase", kind, ex_sect);
    check("addr erase", eaddr, 24'h010000);
    finish_cycle();
    host.start();
    host.put(`SFC_OP_ID_READ, 8);
    host.get(s);
    check("id mfr", s, 8'ha5);
    host.get(s);
    check("id type", s, 8'h3c);
    host.get(s);
    check("id dev", s, 8'h4e);
    host.stop();
    host.start();
    host.put(`SFC_OP_MFR_DEV, 8);
    host.put(8'h00, 8);
    host.put(8'h00, 8);
    host.put(8'h01, 8);
    host.get(s);
    check("alt dev", s, 8'h4e);
    host.get(s);
    check("alt mfr", s, 8'ha5);
    host.stop();
    tx({`SFC_OP_SLEEP, 32'h0}, 1, 0);
    check("power down", pd, 1'b1);
    tx({`SFC_OP_WR_ON, 32'h0}, 1, 0);
    tx({`SFC_OP_WAKE_ID, 32'h0}, 1, 0);
    check("woken", pd, 1'b0);
    st(s);
    check("write_enable_cmd ignored", s, 8'h00);
    host.start();
    host.put(`SFC_OP_WR_ON, 4);
    host.stop();
    tx({`SFC_OP_WR_ON, 32'h0}, 1, 0);
    st(s);
    check("after abort", s, 8'h02);
    tx({`SFC_OP_VOL_ARM, 32'h0}, 1, 0);
    tx({`SFC_OP_ST_WR, 8'h04, 24'h0}, 2, 0);
    st(s);
    check("volatile status", s, 8'h06);
    tx({`SFC_OP_PROG, 24'hfc0000, 8'h5a}, 5, 0);
    check("go protected", n_go, 2);
    tx({`SFC_OP_QUAD_ON, 32'h0}, 1, 0);
    check("quad on", quad, 1'b1);
    host.start();
    host.putq(`SFC_OP_RST_GO);
    host.stop();
    check("quad unarmed reset", quad, 1'b1);
    host.start();
    host.putq(`SFC_OP_QUAD_OFF);
    host.stop();
    check("quad off", quad, 1'b0);
    tx({`SFC_OP_RST_ARM, 32'h0}, 1, 0);
    tx({`SFC_OP_RST_GO, 32'h0}, 1, 0);
    st(s);
    check("soft reset", s, 8'h00);
    summarize();
  end
endmodule : sfc_flash_cmd_bench
`default_nettype wire
